// >>> hw/cpu_regs.sv
// CPU architectural register file, context stacking and global configuration
`timescale 1ns/1ns
`include "cpu_regs_params.svh"
module cpu_regs #(
  parameter logic [15:0] SP_FORCE_MASK = 16'h0000,
  parameter logic [15:0] SP_FORCE_VAL  = 16'h0000
) (
  // Clock and reset
  input  wire logic                     clk_sys,
  input  wire logic                     rst_n,
  // Execution unit writes and flag updates
  input  wire cpu_regs_pkg::reg_wr_t    exec_wr,
  input  wire cpu_regs_pkg::flag_upd_t  flag_upd,
  input  wire logic                     instr_done,
  // Stack command and memory data
  input  wire cpu_regs_pkg::stk_cmd_t   stk_cmd,
  input  wire logic [7:0]               stk_push_data,
  input  wire logic [7:0]               stk_rd_data,
  input  wire logic                     wake_irq,
  output logic                          stk_mem_we,
  output logic [15:0]                   stk_mem_addr,
  output logic [7:0]                    stk_mem_wdata,
  output logic                          stk_busy,
  output logic                          cpu_parked,
  // Global configuration access
  input  wire logic                     gcr_wr,
  input  wire logic [7:0]               gcr_wdata,
  output logic [7:0]                    gcr_rdata,
  // Debug module access
  input  wire cpu_regs_pkg::dbg_req_t   dbg_req,
  output logic [7:0]                    dbg_rdata,
  // Register contents
  output logic [7:0]                    accumulator,
  output logic [15:0]                   index_first,
  output logic [15:0]                   index_second,
  output logic [23:0]                   instruction_pointer,
  output logic [15:0]                   stack_top_pointer,
  output logic [7:0]                    condition_flags,
  output logic [1:0]                    irq_level,
  // Single-wire debug pin ownership
  output logic                          debug_pin_is_gpio
);
  import cpu_regs_pkg::*;

  logic [7:0]  acc_reg;
  logic [15:0] x_reg;
  logic [15:0] y_reg;
  logic [23:0] pc_reg;
  logic [15:0] sp_reg;
  logic [7:0]  cc_reg;
  logic [7:0]  gcr_reg;
  seq_state_t  seq_reg;
  logic [3:0]  cnt_reg;
  logic        ctx_saved_reg;
  logic [15:0] sp_next;
  logic [7:0]  frame_byte;
  logic [7:0]  dbg_byte;
  logic        pop_ahead;

  // Forced upper stack bits per product variant
  function automatic logic [15:0] sp_fix(input logic [15:0] v);
    sp_fix = (v & ~SP_FORCE_MASK) | (SP_FORCE_VAL & SP_FORCE_MASK);
  endfunction

  // Debug byte lane decode used for reads only; writes decode in each register block
  function automatic logic [7:0] sel_byte(input logic [3:0] a);
    case (a)
      `DBG_OFS_ACC: sel_byte = acc_reg;
      `DBG_OFS_IP_EXT:  sel_byte = pc_reg[23:16];
      `DBG_OFS_IP_HI:   sel_byte = pc_reg[15:8];
      `DBG_OFS_IP_LO:   sel_byte = pc_reg[7:0];
      `DBG_OFS_IDX1_HI: sel_byte = x_reg[15:8];
      `DBG_OFS_IDX1_LO: sel_byte = x_reg[7:0];
      `DBG_OFS_IDX2_HI: sel_byte = y_reg[15:8];
      `DBG_OFS_IDX2_LO: sel_byte = y_reg[7:0];
      `DBG_OFS_STK_HI:  sel_byte = sp_reg[15:8];
      `DBG_OFS_STK_LO:  sel_byte = sp_reg[7:0];
      `DBG_OFS_CC:  sel_byte = cc_reg & ~(8'h01 << `CC_RSV_BIT);
      default:      sel_byte = 8'h00;
    endcase
  endfunction

  // Interrupt frame from index 0: pointer low/high/ext, first index, second index, accumulator, flags
  function automatic logic [7:0] frame_at(input logic [3:0] i);
    case (i)
      4'h0:    frame_at = pc_reg[7:0];
      4'h1:    frame_at = pc_reg[15:8];
      4'h2:    frame_at = pc_reg[23:16];
      4'h3:    frame_at = x_reg[7:0];
      4'h4:    frame_at = x_reg[15:8];
      4'h5:    frame_at = y_reg[7:0];
      4'h6:    frame_at = y_reg[15:8];
      4'h7:    frame_at = acc_reg;
      default: frame_at = cc_reg;
    endcase
  endfunction

  assign frame_byte = frame_at(cnt_reg);
  assign dbg_byte   = sel_byte(dbg_req.addr);

  // Frame sequencer; pops run with counter descending for reverse order
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      seq_reg       <= SEQ_IDLE;
      cnt_reg       <= 4'h0;
      ctx_saved_reg <= 1'b0;
    end else begin
      case (seq_reg)
        SEQ_IDLE: begin
          case (stk_cmd)
            STK_IRQ: begin
              if (ctx_saved_reg) begin
                ctx_saved_reg <= 1'b0;
              end else begin
                seq_reg <= SEQ_PUSH;
                cnt_reg <= 4'h0;
              end
            end
            STK_PARK: begin
              seq_reg <= SEQ_PUSH;
              cnt_reg <= 4'h0;
              ctx_saved_reg <= 1'b1;
            end
            STK_RETURN: begin
              if (gcr_reg[`GCR_ACT_LVL_BIT]) begin
                seq_reg       <= SEQ_WAIT;
                ctx_saved_reg <= 1'b1;
              end else begin
                seq_reg <= SEQ_POP;
                cnt_reg <= `INT_FRAME_BYTES - 4'h1;
              end
            end
            default: ;
          endcase
        end
        SEQ_PUSH: begin
          if (cnt_reg == `INT_FRAME_BYTES - 4'h1) begin
            seq_reg <= ctx_saved_reg ? SEQ_WAIT : SEQ_IDLE;
          end else begin
            cnt_reg <= cnt_reg + 4'h1;
          end
        end
        SEQ_POP: begin
          if (cnt_reg == 4'h0) begin
            seq_reg <= SEQ_IDLE;
          end else begin
            cnt_reg <= cnt_reg - 4'h1;
          end
        end
        SEQ_WAIT: begin
          // Frame already on stack, so the wake skips stacking
          if (wake_irq) begin
            seq_reg       <= SEQ_IDLE;
            ctx_saved_reg <= 1'b0;
          end
        end
        default: seq_reg <= SEQ_IDLE;
      endcase
    end
  end

  // Stack pointer next value
  always_comb begin
    sp_next = sp_reg;
    if (seq_reg == SEQ_PUSH || (seq_reg == SEQ_IDLE && stk_cmd == STK_PUSH)) begin
      sp_next = sp_reg - 16'h0001;
    end else if (seq_reg == SEQ_POP || (seq_reg == SEQ_IDLE && stk_cmd == STK_POP)) begin
      sp_next = sp_reg + 16'h0001;
    end
  end

  // Memory answers in the same cycle, so each return pop address is set up one cycle ahead
  assign pop_ahead = (seq_reg == SEQ_POP && cnt_reg != 4'h0) ||
                     (seq_reg == SEQ_IDLE && stk_cmd == STK_RETURN && !gcr_reg[`GCR_ACT_LVL_BIT]);

  // Stack memory port; a return pop reads the byte above the pointer, a plain pop addresses the pointer itself
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      stk_mem_we    <= 1'b0;
      stk_mem_addr  <= 16'h0000;
      stk_mem_wdata <= 8'h00;
    end else begin
      stk_mem_we    <= (seq_reg == SEQ_PUSH) || (seq_reg == SEQ_IDLE && stk_cmd == STK_PUSH);
      stk_mem_addr  <= pop_ahead ? sp_fix(sp_next + 16'h0001) : sp_reg;
      stk_mem_wdata <= (seq_reg == SEQ_PUSH) ? frame_byte : stk_push_data;
    end
  end

  // Stack pointer
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sp_reg <= sp_fix(`SP_RESET);
    end else if (dbg_req.wr && dbg_req.addr == `DBG_OFS_STK_HI) begin
      sp_reg <= sp_fix({dbg_req.wdata, sp_reg[7:0]});
    end else if (dbg_req.wr && dbg_req.addr == `DBG_OFS_STK_LO) begin
      sp_reg <= sp_fix({sp_reg[15:8], dbg_req.wdata});
    end else if (exec_wr.sp_we && seq_reg == SEQ_IDLE) begin
      sp_reg <= sp_fix(exec_wr.sp);
    end else begin
      sp_reg <= sp_fix(sp_next);
    end
  end

  // Accumulator; popped bytes land in reverse order
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      acc_reg <= 8'h00;
    end else if (seq_reg == SEQ_POP) begin
      if (cnt_reg == 4'h7) begin
        acc_reg <= stk_rd_data;
      end
    end else if (dbg_req.wr && dbg_req.addr == `DBG_OFS_ACC) begin
      acc_reg <= dbg_req.wdata;
    end else if (exec_wr.acc_we) begin
      acc_reg <= exec_wr.acc;
    end
  end

  // First index register; a debug byte write beats a same-cycle execution write
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      x_reg <= 16'h0000;
    end else if (seq_reg == SEQ_POP) begin
      case (cnt_reg)
        4'h4:    x_reg[15:8] <= stk_rd_data;
        4'h3:    x_reg[7:0]  <= stk_rd_data;
        default: ;
      endcase
    end else begin
      if (exec_wr.x_we) x_reg <= exec_wr.x;
      case (dbg_req.wr ? dbg_req.addr : 4'hF)
        `DBG_OFS_IDX1_HI: x_reg[15:8] <= dbg_req.wdata;
        `DBG_OFS_IDX1_LO: x_reg[7:0]  <= dbg_req.wdata;
        default: ;
      endcase
    end
  end

  // Second index register, same priorities as the first
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      y_reg <= 16'h0000;
    end else if (seq_reg == SEQ_POP) begin
      case (cnt_reg)
        4'h6:    y_reg[15:8] <= stk_rd_data;
        4'h5:    y_reg[7:0]  <= stk_rd_data;
        default: ;
      endcase
    end else begin
      if (exec_wr.y_we) y_reg <= exec_wr.y;
      case (dbg_req.wr ? dbg_req.addr : 4'hF)
        `DBG_OFS_IDX2_HI: y_reg[15:8] <= dbg_req.wdata;
        `DBG_OFS_IDX2_LO: y_reg[7:0]  <= dbg_req.wdata;
        default: ;
      endcase
    end
  end

  // Instruction pointer, refreshed when an instruction retires
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pc_reg <= 24'h000000;
    end else if (seq_reg == SEQ_POP) begin
      case (cnt_reg)
        4'h2: pc_reg[23:16] <= stk_rd_data;
        4'h1: pc_reg[15:8]  <= stk_rd_data;
        4'h0: pc_reg[7:0]   <= stk_rd_data;
        default: ;
      endcase
    end else if (dbg_req.wr && dbg_req.addr == `DBG_OFS_IP_EXT) begin
      pc_reg[23:16] <= dbg_req.wdata;
    end else if (dbg_req.wr && dbg_req.addr == `DBG_OFS_IP_HI) begin
      pc_reg[15:8] <= dbg_req.wdata;
    end else if (dbg_req.wr && dbg_req.addr == `DBG_OFS_IP_LO) begin
      pc_reg[7:0] <= dbg_req.wdata;
    end else if (instr_done && exec_wr.pc_we) begin
      pc_reg <= exec_wr.pc;
    end
  end

  // Condition flags; execution loads masked fields, bit 6 held at zero
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cc_reg <= `CC_RESET;
    end else if (seq_reg == SEQ_POP && cnt_reg == 4'h8) begin
      cc_reg <= stk_rd_data & ~(8'h01 << `CC_RSV_BIT);
    end else if (seq_reg == SEQ_PUSH && cnt_reg == `INT_FRAME_BYTES - 4'h1 && !ctx_saved_reg) begin
      cc_reg[`CC_MASK_HI_BIT] <= 1'b1;
      cc_reg[`CC_MASK_LO_BIT] <= 1'b1;
    end else if (seq_reg == SEQ_WAIT && wake_irq) begin
      cc_reg[`CC_MASK_HI_BIT] <= 1'b1;
      cc_reg[`CC_MASK_LO_BIT] <= 1'b1;
    end else if (dbg_req.wr && dbg_req.addr == `DBG_OFS_CC) begin
      cc_reg <= dbg_req.wdata & ~(8'h01 << `CC_RSV_BIT);
    end else begin
      // V,H,N,Z,C and mask bits computed by execution
      cc_reg <= ((cc_reg & ~flag_upd.mask) | (flag_upd.value & flag_upd.mask)) & ~(8'h01 << `CC_RSV_BIT);
    end
  end

  // Global configuration; only low two bits store
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      gcr_reg <= `GCR_RESET;
    end else if (gcr_wr) begin
      gcr_reg <= gcr_wdata & 8'h03;
    end
  end

  // Debug read data stands one cycle, zero when no read
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      dbg_rdata <= 8'h00;
    end else begin
      dbg_rdata <= dbg_req.rd ? dbg_byte : 8'h00;
    end
  end

  // Config readback and pin ownership; reset hands the pin to the debug tool
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      gcr_rdata         <= `GCR_RESET;
      debug_pin_is_gpio <= 1'b0;
    end else begin
      gcr_rdata         <= gcr_reg;
      debug_pin_is_gpio <= gcr_reg[`GCR_DBG_OFF_BIT];
    end
  end

  // Sequencer status, one cycle behind the state
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      stk_busy   <= 1'b0;
      cpu_parked <= 1'b0;
    end else begin
      stk_busy   <= (seq_reg == SEQ_PUSH) || (seq_reg == SEQ_POP);
      cpu_parked <= (seq_reg == SEQ_WAIT);
    end
  end

  // Register mirrors trail the registers by one cycle
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      accumulator <= 8'h00;
    end else begin
      accumulator <= acc_reg;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      index_first  <= 16'h0000;
      index_second <= 16'h0000;
    end else begin
      index_first  <= x_reg;
      index_second <= y_reg;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      instruction_pointer <= 24'h000000;
    end else begin
      instruction_pointer <= pc_reg;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      stack_top_pointer <= 16'h0000;
    end else begin
      stack_top_pointer <= sp_reg;
    end
  end

  // Level taken from the same flags value, so the pair never disagrees
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      condition_flags <= 8'h00;
      irq_level       <= 2'b00;
    end else begin
      condition_flags <= cc_reg;
      irq_level       <= {cc_reg[`CC_MASK_HI_BIT], cc_reg[`CC_MASK_LO_BIT]};
    end
  end
endmodule

// >>> include/cpu_regs_params.svh
// Offsets, field positions, reset values and frame byte count for the CPU register file
// Behaviour
// - One 8-bit accumulator holds operands and results.
// - Two 16-bit index registers for addressing, data and multiply/divide.
// - 24-bit instruction pointer, refreshed after every executed instruction.
// - 16-bit stack pointer, decremented per byte pushed, incremented per byte popped.
// - Variant may force upper stack pointer bits to a preset value.
// - Interrupt entry pushes nine bytes, all but stack pointer; call uses two/three.
// - Interrupt return pops saved registers in exact reverse push order.
// - Wait or halt saves context ahead so interrupt latency shrinks.
// - 8-bit condition flags register; bit 6 reserved.
// - Overflow flag set on signed arithmetic overflow of result MSB.
// - Mask pair: 10 main, 01 level1, 00 level2, 11 non-interruptable.
// - Both mask bits set on service entry; instructions may also change them.
// - Half-carry set on carry from bit 3 into bit 4 by add.
// - Negative flag copies result most significant bit.
// - Zero flag set when result is zero, cleared otherwise.
// - Carry flag set on carry/borrow out; divide reports overflow or zero divisor.
// - Carry loaded by bit test, updated by shifts, set/clear/complement by software.
// - Registers at debug offsets 0x00-0x0A, debug module only.
// - Global config resets to 0x00; only bits 1 and 0 writable.
// - Activation bit clear: return restores; set: re-enter wait without restore.
// - Debug-disable bit frees single-wire pin as GPIO; else pin stays debug.
// - After any reset the single-wire pin serves the external debug tool.
`ifndef CPU_REGS_PARAMS_SVH
`define CPU_REGS_PARAMS_SVH
`define DBG_OFS_ACC      4'h0
`define DBG_OFS_IP_EXT   4'h1
`define DBG_OFS_IP_HI    4'h2
`define DBG_OFS_IP_LO    4'h3
`define DBG_OFS_IDX1_HI  4'h4
`define DBG_OFS_IDX1_LO  4'h5
`define DBG_OFS_IDX2_HI  4'h6
`define DBG_OFS_IDX2_LO  4'h7
`define DBG_OFS_STK_HI   4'h8
`define DBG_OFS_STK_LO   4'h9
`define DBG_OFS_CC       4'hA
`define GCR_OFS          1'b0
`define GCR_RESET        8'h00
`define GCR_ACT_LVL_BIT  1
`define GCR_DBG_OFF_BIT  0
`define CC_V_BIT         7
`define CC_RSV_BIT       6
`define CC_MASK_HI_BIT   5
`define CC_H_BIT         4
`define CC_MASK_LO_BIT   3
`define CC_N_BIT         2
`define CC_Z_BIT         1
`define CC_C_BIT         0
`define CC_RESET         8'h28
`define SP_RESET         16'h03FF
`define INT_FRAME_BYTES  4'h9
`endif

// >>> include/cpu_regs_pkg.sv
// Types shared by the CPU register file and its neighbours
package cpu_regs_pkg;
  // Flag update from execution: which flags to load and their values
  typedef struct packed {
    logic [7:0] mask;
    logic [7:0] value;
  } flag_upd_t;
  // Debug register access
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [3:0] addr;
    logic [7:0] wdata;
  } dbg_req_t;
  // Execution-unit register writes
  typedef struct packed {
    logic        acc_we;
    logic [7:0]  acc;
    logic        x_we;
    logic [15:0] x;
    logic        y_we;
    logic [15:0] y;
    logic        pc_we;
    logic [23:0] pc;
    logic        sp_we;
    logic [15:0] sp;
  } reg_wr_t;
  // Stack commands
  typedef enum logic [5:0] {
    STK_IDLE  = 6'h01,
    STK_PUSH  = 6'h02,
    STK_POP   = 6'h04,
    STK_IRQ   = 6'h08,
    STK_RETURN = 6'h10,
    STK_PARK  = 6'h20
  } stk_cmd_t;
  // Sequencer states, one-hot
  typedef enum logic [3:0] {
    SEQ_IDLE = 4'h1,
    SEQ_PUSH = 4'h2,
    SEQ_POP  = 4'h4,
    SEQ_WAIT = 4'h8
  } seq_state_t;
endpackage

// >>> testbench/cpu_regs_asserts.sv
// Port-level checks for the CPU register file
`timescale 1ns/1ns
module cpu_regs_asserts (
  // Clock and reset
  input wire logic                   clk_sys,
  input wire logic                   rst_n,
  // Stack side
  input wire cpu_regs_pkg::stk_cmd_t stk_cmd,
  input wire logic                   wake_irq,
  input wire logic                   stk_mem_we,
  input wire logic                   stk_busy,
  input wire logic                   cpu_parked,
  // Debug and configuration
  input wire cpu_regs_pkg::dbg_req_t dbg_req,
  input wire logic [7:0]             dbg_rdata,
  input wire logic                   gcr_wr,
  input wire logic [7:0]             gcr_wdata,
  input wire logic [7:0]             gcr_rdata,
  input wire logic                   debug_pin_is_gpio,
  // Register mirrors
  input wire logic [15:0]            stack_top_pointer,
  input wire logic [7:0]             condition_flags,
  input wire logic [1:0]             irq_level
);
  import cpu_regs_pkg::*;
  logic [3:0]  wr_cnt;
  logic [15:0] sp_cap;
  logic        idle_ok;
  assign idle_ok = !stk_busy && !cpu_parked;
  // Counted from the accepted entry, so stray pops never add
  always_ff @(posedge clk_sys) begin
    if (!rst_n || (stk_cmd == STK_IRQ && idle_ok)) begin
      wr_cnt <= 4'h0;
    end else if (stk_mem_we) begin
      wr_cnt <= wr_cnt + 4'h1;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (stk_cmd == STK_PUSH && idle_ok) begin
      sp_cap <= stack_top_pointer;
    end
  end
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  sequence irq_taken;
    stk_cmd == STK_IRQ && idle_ok;
  endsequence
  sequence push_taken;
    stk_cmd == STK_PUSH && idle_ok;
  endsequence
  a_reset_clean: assert property ($rose(rst_n) |-> gcr_rdata == 8'h00 && !debug_pin_is_gpio)
    else $error("outputs not clear after reset");
  a_gcr_reserved: assert property (gcr_rdata[7:2] == 6'h00)
    else $error("reserved config bits set");
  a_cc_reserved: assert property (condition_flags[6] == 1'b0)
    else $error("reserved flag bit set");
  a_level_pair: assert property (irq_level == {condition_flags[5], condition_flags[3]})
    else $error("level differs from mask bits");
  a_swd_frees: assert property (gcr_wr && gcr_wdata[0] |-> ##[1:3] debug_pin_is_gpio)
    else $error("debug pin not freed");
  a_frame_nine: assert property (irq_taken |-> ##12 wr_cnt == 4'h9)
    else $error("frame byte count wrong");
  a_entry_mask: assert property (irq_taken |-> ##[10:14] irq_level == 2'b11)
    else $error("mask not set on entry");
  a_push_dec: assert property (push_taken |-> ##[2:4] stack_top_pointer == sp_cap - 16'h0001)
    else $error("push did not decrement");
  a_unmapped_rd: assert property (dbg_req.rd && dbg_req.addr > 4'hA |=> dbg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_wake_mask: assert property (cpu_parked && wake_irq |-> ##[1:3] !cpu_parked ##[0:2] irq_level == 2'b11)
    else $error("wake did not leave wait");
  a_al_park: assert property (stk_cmd == STK_RETURN && idle_ok && gcr_rdata[1] |-> ##[1:3] cpu_parked)
    else $error("return did not re-enter wait");
endmodule
bind cpu_regs cpu_regs_asserts u_chk (.clk_sys(clk_sys), .rst_n(rst_n), .stk_cmd(stk_cmd), .wake_irq(wake_irq),
  .stk_mem_we(stk_mem_we), .stk_busy(stk_busy), .cpu_parked(cpu_parked), .dbg_req(dbg_req),
  .dbg_rdata(dbg_rdata), .gcr_wr(gcr_wr), .gcr_wdata(gcr_wdata), .gcr_rdata(gcr_rdata),
  .debug_pin_is_gpio(debug_pin_is_gpio), .stack_top_pointer(stack_top_pointer),
  .condition_flags(condition_flags), .irq_level(irq_level));

// >>> testbench/stack_ram_model.sv
// Stack memory on the far side of the stacking port
`timescale 1ns/1ns
module stack_ram_model (
  // Clock
  input  wire logic        clk_sys,
  // Stack port
  input  wire logic        stk_mem_we,
  input  wire logic [15:0] stk_mem_addr,
  input  wire logic [7:0]  stk_mem_wdata,
  output logic [7:0]       stk_rd_data
);
  // Only 1 KiB kept; upper address bits fold onto it
  logic [7:0] mem [0:1023];
  always_ff @(posedge clk_sys) begin
    if (stk_mem_we) begin
      mem[stk_mem_addr[9:0]] <= stk_mem_wdata;
    end
  end
  // Same-cycle read: pops sample it in the addressing cycle
  assign stk_rd_data = mem[stk_mem_addr[9:0]];
endmodule

// >>> testbench/cpu_register_file_and_global_config_test.sv
// Self-checking bench for the CPU register file
`timescale 1ns/1ns
`include "cpu_regs_params.svh"
module cpu_register_file_and_global_config_test;
  import cpu_regs_pkg::*;
  logic        clk_sys, rst_n, instr_done, wake_irq, gcr_wr, stk_mem_we, stk_busy, cpu_parked, debug_pin_is_gpio;
  reg_wr_t     exec_wr;
  flag_upd_t   flag_upd;
  stk_cmd_t    stk_cmd;
  dbg_req_t    dbg_req;
  logic [7:0]  stk_push_data, stk_rd_data, stk_mem_wdata, gcr_wdata, gcr_rdata, dbg_rdata, accumulator, condition_flags;
  logic [15:0] stk_mem_addr, index_first, index_second, stack_top_pointer;
  logic [23:0] instruction_pointer;
  logic [1:0]  irq_level;
  int          miscompares = 0;
  int          tests_run = 0;
  cpu_regs dut (.clk_sys(clk_sys), .rst_n(rst_n), .exec_wr(exec_wr), .flag_upd(flag_upd), .instr_done(instr_done),
    .stk_cmd(stk_cmd), .stk_push_data(stk_push_data), .stk_rd_data(stk_rd_data), .wake_irq(wake_irq),
    .stk_mem_we(stk_mem_we), .stk_mem_addr(stk_mem_addr), .stk_mem_wdata(stk_mem_wdata), .stk_busy(stk_busy),
    .cpu_parked(cpu_parked), .gcr_wr(gcr_wr), .gcr_wdata(gcr_wdata), .gcr_rdata(gcr_rdata), .dbg_req(dbg_req),
    .dbg_rdata(dbg_rdata), .accumulator(accumulator), .index_first(index_first), .index_second(index_second),
    .instruction_pointer(instruction_pointer), .stack_top_pointer(stack_top_pointer),
    .condition_flags(condition_flags), .irq_level(irq_level), .debug_pin_is_gpio(debug_pin_is_gpio));
  stack_ram_model ram (.clk_sys(clk_sys), .stk_mem_we(stk_mem_we), .stk_mem_addr(stk_mem_addr),
    .stk_mem_wdata(stk_mem_wdata), .stk_rd_data(stk_rd_data));
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  task automatic check(input logic [23:0] seen, input logic [23:0] want);
    tests_run++;
    if (seen !== want) begin
      miscompares++;
      $display("mismatch at %0t: saw %0h expected %0h", $time, seen, want);
    end
  endtask
  task automatic results;
    $display("checks %0d, miscompares %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic ticks(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic exec(input reg_wr_t w);
    @(posedge clk_sys);
    exec_wr <= w;
    instr_done <= w.pc_we;
    @(posedge clk_sys);
    exec_wr <= '0;
    instr_done <= 1'b0;
    ticks(2);
  endtask
  task automatic dbg(input logic wr, input logic [3:0] a, input logic [7:0] v, output logic [7:0] d);
    @(posedge clk_sys);
    dbg_req <= '{!wr, wr, a, v};
    @(posedge clk_sys);
    dbg_req <= '0;
    #1 d = dbg_rdata;
    ticks(2);
  endtask
  task automatic pulse_in(input logic is_wake, input logic [7:0] v);
    @(posedge clk_sys);
    wake_irq <= is_wake;
    gcr_wr <= !is_wake;
    gcr_wdata <= v;
    @(posedge clk_sys);
    wake_irq <= 1'b0;
    gcr_wr <= 1'b0;
    ticks(2);
  endtask
  // Busy rises a cycle late, so polling starts one edge after release
  task automatic cmd(input stk_cmd_t c, input logic [7:0] v);
    @(posedge clk_sys);
    stk_cmd <= c;
    stk_push_data <= v;
    @(posedge clk_sys);
    stk_cmd <= STK_IDLE;
    ticks(1);
    for (int i = 0; i < 40 && stk_busy !== 1'b0; i++) ticks(1);
    if (stk_busy !== 1'b0) begin
      miscompares++;
      $display("mismatch at %0t: stack sequence hung", $time);
      results();
    end
    ticks(2);
  endtask
  task automatic regs_test;
    logic [7:0] d;
    logic [7:0] want [11] = '{8'h5A, 8'h12, 8'h34, 8'h56, 8'h12, 8'h34, 8'hAB, 8'hCD, 8'h03, 8'h00, 8'h28};
    check(stack_top_pointer, `SP_RESET);
    check(irq_level, 2'b11);
    check(gcr_rdata, `GCR_RESET);
    check(debug_pin_is_gpio, 1'b0);
    exec('{1'b1, 8'h5A, 1'b1, 16'h1234, 1'b1, 16'hABCD, 1'b1, 24'h123456, 1'b1, 16'h0300});
    for (int i = 0; i < 11; i++) begin
      dbg(1'b0, 4'(i), 8'h00, d);
      check(d, want[i]);
    end
    dbg(1'b0, 4'hB, 8'h00, d);
    check(d, 8'h00);
    dbg(1'b1, 4'h0, 8'hC3, d);
    check(accumulator, 8'hC3);
    $display("test registers done");
  endtask
  task automatic flags_test;
    logic [7:0] m [7] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h97, 8'hFF};
    logic [7:0] v [7] = '{8'hFF, 8'h28, 8'h20, 8'h08, 8'h00, 8'hFF, 8'h00};
    logic [7:0] e [7] = '{8'hBF, 8'h28, 8'h20, 8'h08, 8'h00, 8'h97, 8'h00};
    logic [1:0] l [7] = '{2'b11, 2'b11, 2'b10, 2'b01, 2'b00, 2'b00, 2'b00};
    for (int i = 0; i < 7; i++) begin
      @(posedge clk_sys);
      flag_upd <= '{m[i], v[i]};
      @(posedge clk_sys);
      flag_upd <= '0;
      ticks(2);
      check(condition_flags, e[i]);
      check(irq_level, l[i]);
    end
    $display("test flags done");
  endtask
  task automatic stack_test;
    logic [7:0] frame [9] = '{8'h56, 8'h34, 8'h12, 8'h34, 8'h12, 8'hCD, 8'hAB, 8'hC3, 8'h00};
    cmd(STK_PUSH, 8'h77);
    check(stack_top_pointer, 16'h02FF);
    check(ram.mem[10'h300], 8'h77);
    cmd(STK_POP, 8'h00);
    check(stack_top_pointer, 16'h0300);
    cmd(STK_IRQ, 8'h00);
    check(stack_top_pointer, 16'h02F7);
    check(irq_level, 2'b11);
    for (int i = 0; i < 9; i++) check(ram.mem[10'h300 - 10'(i)], frame[i]);
    exec('{1'b1, 8'h00, 1'b1, 16'h0000, 1'b1, 16'h0000, 1'b1, 24'h000000, 1'b0, 16'h0000});
    cmd(STK_RETURN, 8'h00);
    check(accumulator, 8'hC3);
    check(index_first, 16'h1234);
    check(index_second, 16'hABCD);
    check(instruction_pointer, 24'h123456);
    check(condition_flags, 8'h00);
    check(stack_top_pointer, 16'h0300);
    $display("test stacking done");
  endtask
  task automatic park_test;
    pulse_in(1'b0, 8'hFF);
    check(gcr_rdata, 8'h03);
    check(debug_pin_is_gpio, 1'b1);
    pulse_in(1'b0, 8'h02);
    check(debug_pin_is_gpio, 1'b0);
    cmd(STK_RETURN, 8'h00);
    check(cpu_parked, 1'b1);
    check(stack_top_pointer, 16'h0300);
    pulse_in(1'b1, 8'h00);
    check(cpu_parked, 1'b0);
    check(irq_level, 2'b11);
    pulse_in(1'b0, 8'h00);
    cmd(STK_PARK, 8'h00);
    check(cpu_parked, 1'b1);
    check(stack_top_pointer, 16'h02F7);
    pulse_in(1'b1, 8'h00);
    check(cpu_parked, 1'b0);
    $display("test wait done");
  endtask
  initial begin
    rst_n = 1'b0;
    exec_wr = '0;
    flag_upd = '0;
    instr_done = 1'b0;
    stk_cmd = STK_IDLE;
    stk_push_data = 8'h00;
    wake_irq = 1'b0;
    gcr_wr = 1'b0;
    gcr_wdata = 8'h00;
    dbg_req = '0;
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    ticks(2);
    regs_test();
    flags_test();
    stack_test();
    park_test();
    results();
  end
endmodule
